// ==== bench/periph_req_model.sv ====
`timescale 1ns/1ps
// Converter and comparator asking for their references
module periph_req_model (
  // Clock
  input wire logic hclk,
  // Wishes from the bench, converter in bit 1
  input wire logic [1:0] want,
  // Requests towards the block
  output logic conv_req,
  output logic comp_req
);
  // Requests move just after an edge and stay level while a source is needed
  always_ff @(posedge hclk) begin
    conv_req <= want[1];
    comp_req <= want[0];
  end
endmodule : periph_req_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps
module testbench;
  logic hclk, hresetn, hready, hreadyout, hresp, hwrite, conv_req, comp_req, conv_en, comp_en;
  logic [1:0] htrans, want;
  logic [2:0] conv_sel, comp_sel;
  logic [31:0] haddr, hwdata, hrdata, q;
  int num_errors = 0;
  int cmp_count = 0;
  // One slave, so its ready is the bus ready
  assign hready = hreadyout;
  // Clock at 125 MHz
  initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
  end
  voltage_reference_control u_voltage_reference_control (.hclk(hclk), .hresetn(hresetn),
    .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .converter_peripheral_request(conv_req), .converter_source_enable(conv_en),
    .converter_level_select(conv_sel), .comparator_peripheral_request(comp_req),
    .comparator_source_enable(comp_en), .comparator_level_select(comp_sel));
  periph_req_model u_periph_req_model (.hclk(hclk), .want(want), .conv_req(conv_req),
    .comp_req(comp_req));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // One single AHB transfer; waits for ready under a bound, read data lands in q
  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge hclk);
    haddr <= a;
    hwrite <= w;
    htrans <= vref_ctrl_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1 && n++ < 20);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && n++ < 20);
    q = hrdata;
    chk(32'(hresp), 32'(vref_ctrl_pkg::HRESP_OKAY));
    chk(32'(hreadyout), 32'h1);
    if (n >= 20) num_errors++;
  endtask : bus
  // Registers and enables after reset
  task automatic t_reset;
    chk(32'({conv_en, comp_en}), 32'h0);
    bus(vref_ctrl_pkg::LEVEL_SELECT_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(vref_ctrl_pkg::FORCE_ENABLE_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test reset done");
  endtask : t_reset
  // Reset in mid-run clears written levels and forces
  task automatic t_midrun_reset;
    bus(vref_ctrl_pkg::LEVEL_SELECT_ADDR, 1'b1, 32'h0000_0043);
    bus(vref_ctrl_pkg::FORCE_ENABLE_ADDR, 1'b1, 32'h0000_0003);
    want <= 2'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    #1;
    chk(32'({conv_en, comp_en}), 32'h0);
    chk(32'({conv_sel, comp_sel}), 32'h0);
    bus(vref_ctrl_pkg::LEVEL_SELECT_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(vref_ctrl_pkg::FORCE_ENABLE_ADDR, 1'b0, 32'h0);
    chk(q, 32'h0);
    $display("test midrun reset done");
  endtask : t_midrun_reset
  // Every code in both fields, reserved bits set on write, then an unmapped place
  task automatic t_levels;
    for (int c = 0; c < 8; c++) begin
      bus(vref_ctrl_pkg::LEVEL_SELECT_ADDR, 1'b1, 32'(32'hFFFF_FF88 | (c << 4) | (7 - c)));
      #1;
      chk(32'(conv_sel), 32'(c));
      chk(32'(comp_sel), 32'(7 - c));
      bus(vref_ctrl_pkg::LEVEL_SELECT_ADDR, 1'b0, 32'h0);
      chk(q, 32'((c << 4) | (7 - c)));
    end
    bus(32'h0000_0008, 1'b1, 32'h0000_00FF);
    bus(32'h0000_0008, 1'b0, 32'h0);
    chk(q, 32'h0);
    bus(vref_ctrl_pkg::LEVEL_SELECT_ADDR, 1'b0, 32'h0);
    chk(q, 32'h70);
    $display("test levels done");
  endtask : t_levels
  // All mixes of request and force, so clearing a force is seen too
  task automatic t_enables;
    for (int k = 0; k < 16; k++) begin
      bus(vref_ctrl_pkg::FORCE_ENABLE_ADDR, 1'b1, 32'(32'hFFFF_FFFC | k[3:2]));
      want <= k[1:0];
      repeat (2) @(posedge hclk);
      #1;
      chk(32'(conv_en), 32'(k[3] | k[1]));
      chk(32'(comp_en), 32'(k[2] | k[0]));
      bus(vref_ctrl_pkg::FORCE_ENABLE_ADDR, 1'b0, 32'h0);
      chk(q, 32'(k[3:2]));
    end
    $display("test enables done");
  endtask : t_enables
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100000;
    num_errors++;
    give_verdict;
  end
  initial begin
    hresetn = 1'b0;
    want = 2'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_levels;
    t_enables;
    t_midrun_reset;
    give_verdict;
  end
endmodule : testbench

// ==== logic/voltage_reference_control.sv ====
// Local design decision: the AHB-Lite register port.
`timescale 1ns/1ps

// What this block does
// (R1) Converter level select in bits 6:4, R/W
// (R2) Comparator level select in bits 2:0, independent
// (R3) Comparator codes match converter level codes
// (R4) Source on while its peripheral requests it
// (R5) Force register bits keep sources running
// (R6) Both registers reset to zero
// (R7) Clearing force returns source to request control
// (R8) Enable is request OR force, select beside
module voltage_reference_control (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Converter peripheral
  input wire logic converter_peripheral_request,
  output logic converter_source_enable,
  output logic [2:0] converter_level_select,
  // Comparator peripheral
  input wire logic comparator_peripheral_request,
  output logic comparator_source_enable,
  output logic [2:0] comparator_level_select
);

  // All state of the block
  typedef struct packed {
    logic [2:0] conv_sel;
    logic [2:0] comp_sel;
    logic conv_force;
    logic comp_force;
    logic wr_pend;
    logic [1:0] wr_reg;
    logic [31:0] rdata;
    logic conv_en;
    logic comp_en;
  } state_s;

  state_s st_r;
  state_s st_nxt;

  // Address phase decode
  logic addr_valid;
  logic [1:0] addr_reg;

  // Decode which register an accepted transfer targets; 00 means unmapped
  always_comb begin
    addr_valid = hsel && hready && (htrans == vref_ctrl_pkg::HTRANS_NONSEQ ||
                                    htrans == vref_ctrl_pkg::HTRANS_SEQ);
    if (haddr == vref_ctrl_pkg::LEVEL_SELECT_ADDR) begin
      addr_reg = 2'h1;
    end else if (haddr == vref_ctrl_pkg::FORCE_ENABLE_ADDR) begin
      addr_reg = 2'h2;
    end else begin
      addr_reg = 2'h0;
    end
  end

  // Next state: the pending write lands first so a read right after sees it
  always_comb begin
    st_nxt = st_r;
    st_nxt.wr_pend = 1'b0;
    if (st_r.wr_pend) begin
      if (st_r.wr_reg == 2'h1) begin
        st_nxt.conv_sel = hwdata[vref_ctrl_pkg::CONV_SEL_MSB:vref_ctrl_pkg::CONV_SEL_LSB]; // see (R1)
        st_nxt.comp_sel = hwdata[vref_ctrl_pkg::COMP_SEL_MSB:vref_ctrl_pkg::COMP_SEL_LSB]; // see (R2)
      end else if (st_r.wr_reg == 2'h2) begin
        // Writing zero hands the source back to its request line
        st_nxt.conv_force = hwdata[vref_ctrl_pkg::CONV_FORCE_BIT]; // see (R5) see (R7)
        st_nxt.comp_force = hwdata[vref_ctrl_pkg::COMP_FORCE_BIT]; // see (R5) see (R7)
      end
    end
    if (addr_valid) begin
      st_nxt.wr_pend = hwrite;
      st_nxt.wr_reg = addr_reg;
      // Reserved bits 7 and 3 read as zero; reserved codes are stored as written
      if (hwrite) begin
        st_nxt.rdata = st_r.rdata;
      end else if (addr_reg == 2'h1) begin
        st_nxt.rdata = {25'h0, st_nxt.conv_sel, 1'b0, st_nxt.comp_sel}; // see (R3)
      end else if (addr_reg == 2'h2) begin
        st_nxt.rdata = {30'h0, st_nxt.conv_force, st_nxt.comp_force};
      end else begin
        st_nxt.rdata = 32'h0;
      end
    end
    // Enable follows request OR force one cycle later, from a flop
    st_nxt.conv_en = converter_peripheral_request | st_r.conv_force; // see (R4) see (R8)
    st_nxt.comp_en = comparator_peripheral_request | st_r.comp_force; // see (R4) see (R8)
  end

  // State register; both control registers clear on reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r.conv_sel <= vref_ctrl_pkg::LEVEL_SELECT_RESET[6:4]; // see (R6)
      st_r.comp_sel <= vref_ctrl_pkg::LEVEL_SELECT_RESET[2:0]; // see (R6)
      st_r.conv_force <= vref_ctrl_pkg::FORCE_ENABLE_RESET[1]; // see (R6)
      st_r.comp_force <= vref_ctrl_pkg::FORCE_ENABLE_RESET[0]; // see (R6)
      st_r.wr_pend <= 1'b0;
      st_r.wr_reg <= 2'h0;
      st_r.rdata <= 32'h0;
      st_r.conv_en <= 1'b0;
      st_r.comp_en <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Read data, enables and selects straight from the state flops; ready and response tied: no wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = vref_ctrl_pkg::HRESP_OKAY;
  assign hrdata = st_r.rdata;
  assign converter_source_enable = st_r.conv_en;
  assign comparator_source_enable = st_r.comp_en;
  assign converter_level_select = st_r.conv_sel; // see (R8)
  assign comparator_level_select = st_r.comp_sel; // see (R8)

  // Checks: every property samples on the bus clock and sleeps while reset is low.
  // They compare what this block drives against the bus and request inputs, so
  // a broken write path or a stuck enable shows up as a failure.
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Write of the level register reaches the converter select
  chk_conv_sel_write: assert property ( // see (R1)
    st_r.wr_pend && st_r.wr_reg == 2'h1 |=> converter_level_select == $past(hwdata[6:4])
  ) else $error("converter select not updated by write");

  // Write of the level register reaches the comparator select
  chk_comp_sel_write: assert property ( // see (R2)
    st_r.wr_pend && st_r.wr_reg == 2'h1 |=> comparator_level_select == $past(hwdata[2:0])
  ) else $error("comparator select not updated by write");

  // Read of the level register shows both fields with gaps as zero
  chk_level_readback: assert property ( // see (R3)
    addr_valid && !hwrite && addr_reg == 2'h1 && !st_r.wr_pend |=>
      hrdata == {25'h0, converter_level_select, 1'b0, comparator_level_select}
  ) else $error("level select read back wrong");

  // Unforced source tracks its request one cycle later
  chk_conv_request: assert property ( // see (R4)
    !st_r.conv_force ##1 !st_r.conv_force |->
      converter_source_enable == $past(converter_peripheral_request)
  ) else $error("converter enable does not follow request");

  // Unforced comparator source switches off without request
  chk_comp_off: assert property ( // see (R4)
    !comparator_peripheral_request && !st_r.comp_force |=> !comparator_source_enable
  ) else $error("comparator source left on");

  // Forced source stays on with no request at all
  chk_force_holds: assert property ( // see (R5)
    st_r.conv_force && !converter_peripheral_request |=> converter_source_enable
  ) else $error("forced converter source dropped");

  // After release both selects and both enables are zero
  chk_reset_zero: assert property ( // see (R6)
    $rose(hresetn) |-> converter_level_select == 3'h0 && comparator_level_select == 3'h0
      && !converter_source_enable && !comparator_source_enable
  ) else $error("state not zero after reset");

  // Clearing force gives the source back to the request two edges on
  chk_force_clear: assert property ( // see (R7)
    st_r.wr_pend && st_r.wr_reg == 2'h2 && !hwdata[0] |-> ##2
      comparator_source_enable == $past(comparator_peripheral_request)
  ) else $error("comparator force clear not honoured");

  // Enable equals request OR force of the previous cycle
  chk_enable_or: assert property ( // see (R8)
    ##1 comparator_source_enable ==
      ($past(comparator_peripheral_request) || $past(st_r.comp_force))
  ) else $error("comparator enable is not request or force");

  // Slave never stalls and always answers OKAY
  chk_bus_okay: assert property (
    hreadyout && hresp == vref_ctrl_pkg::HRESP_OKAY
  ) else $error("slave answered with wait or error");

  // Unforced converter source switches off without request
  chk_conv_off: assert property ( // see (R4)
    !converter_peripheral_request && !st_r.conv_force |=>
      !converter_source_enable
  ) else $error("converter source left on");

  // Unforced comparator source tracks its request one cycle later
  chk_comp_request: assert property ( // see (R4)
    !st_r.comp_force ##1 !st_r.comp_force |->
      comparator_source_enable == $past(comparator_peripheral_request)
  ) else $error("comparator enable does not follow request");

  // A converter request always switches its source on
  chk_conv_on_request: assert property ( // see (R4)
    converter_peripheral_request |=>
      converter_source_enable
  ) else $error("converter request ignored");

  // A comparator request always switches its source on
  chk_comp_on_request: assert property ( // see (R4)
    comparator_peripheral_request |=>
      comparator_source_enable
  ) else $error("comparator request ignored");

  // Forced comparator source stays on with no request
  chk_comp_force_holds: assert property ( // see (R5)
    st_r.comp_force && !comparator_peripheral_request |=>
      comparator_source_enable
  ) else $error("forced comparator source dropped");

  // Write of the force register lands in both force bits
  chk_force_write: assert property ( // see (R5)
    st_r.wr_pend && st_r.wr_reg == 2'h2 |=>
      st_r.conv_force == $past(hwdata[1]) && st_r.comp_force == $past(hwdata[0])
  ) else $error("force bits not updated by write");

  // Setting the converter force turns its source on two edges on
  chk_conv_force_on: assert property ( // see (R5)
    st_r.wr_pend && st_r.wr_reg == 2'h2 && hwdata[1] |-> ##2
      converter_source_enable
  ) else $error("converter force set not honoured");

  // Setting the comparator force turns its source on two edges on
  chk_comp_force_on: assert property ( // see (R5)
    st_r.wr_pend && st_r.wr_reg == 2'h2 && hwdata[0] |-> ##2
      comparator_source_enable
  ) else $error("comparator force set not honoured");

  // Read of the force register shows both bits with the rest zero
  chk_force_readback: assert property ( // see (R5)
    addr_valid && !hwrite && addr_reg == 2'h2 && !st_r.wr_pend |=>
      hrdata == {30'h0, st_r.conv_force, st_r.comp_force}
  ) else $error("force register read back wrong");

  // Force bits move only when their own register is written
  chk_force_hold: assert property ( // see (R5)
    !(st_r.wr_pend && st_r.wr_reg == 2'h2) |=>
      $stable(st_r.conv_force) && $stable(st_r.comp_force)
  ) else $error("force bits changed without a write");

  // Clearing converter force gives the source back to the request
  chk_conv_force_clear: assert property ( // see (R7)
    st_r.wr_pend && st_r.wr_reg == 2'h2 && !hwdata[1] |-> ##2
      converter_source_enable == $past(converter_peripheral_request)
  ) else $error("converter force clear not honoured");

  // Converter enable equals request OR force of the previous cycle
  chk_conv_enable_or: assert property ( // see (R8)
    ##1 converter_source_enable ==
      ($past(converter_peripheral_request) || $past(st_r.conv_force))
  ) else $error("converter enable is not request or force");

  // Converter select moves only when the level register is written
  chk_conv_sel_hold: assert property ( // see (R1)
    !(st_r.wr_pend && st_r.wr_reg == 2'h1) |=>
      $stable(converter_level_select)
  ) else $error("converter select changed without a write");

  // Comparator select moves only when the level register is written
  chk_comp_sel_hold: assert property ( // see (R2)
    !(st_r.wr_pend && st_r.wr_reg == 2'h1) |=>
      $stable(comparator_level_select)
  ) else $error("comparator select changed without a write");

  // Read data stands until the next read is taken
  chk_rdata_stands: assert property (
    !addr_valid || hwrite |=>
      $stable(hrdata)
  ) else $error("read data moved without a read");

  // An unmapped read returns zero
  chk_unmapped_read: assert property (
    addr_valid && !hwrite && addr_reg == 2'h0 |=>
      hrdata == 32'h0
  ) else $error("unmapped read not zero");

  // An unmapped write leaves both level selects alone
  chk_unmapped_write: assert property (
    addr_valid && hwrite && addr_reg == 2'h0 |-> ##2
      $stable(converter_level_select) && $stable(comparator_level_select)
  ) else $error("unmapped write changed a register");

  // Reserved read bits are always zero
  chk_reserved_zero: assert property (
    hrdata[31:7] == 25'h0 &&
      !hrdata[3]
  ) else $error("reserved read bits not zero");

  // After release the force bits and read data are clear
  chk_reset_force_zero: assert property ( // see (R6)
    $rose(hresetn) |->
      !st_r.conv_force && !st_r.comp_force && hrdata == 32'h0
  ) else $error("force or read data not zero after reset");

endmodule : voltage_reference_control

// ==== logic/vref_ctrl_pkg.sv ====
package vref_ctrl_pkg;

  // Register indices as printed; the byte address is four times the index
  localparam logic [7:0] LEVEL_SELECT_IDX = 8'h00;
  localparam logic [7:0] FORCE_ENABLE_IDX = 8'h01;
  localparam logic [31:0] LEVEL_SELECT_ADDR = 32'(LEVEL_SELECT_IDX) * 32'h4;
  localparam logic [31:0] FORCE_ENABLE_ADDR = 32'(FORCE_ENABLE_IDX) * 32'h4;

  // Values after reset
  localparam logic [7:0] LEVEL_SELECT_RESET = 8'h00;
  localparam logic [7:0] FORCE_ENABLE_RESET = 8'h00;

  // Field positions in the level select register
  localparam int CONV_SEL_LSB = 4;
  localparam int CONV_SEL_MSB = 6;
  localparam int COMP_SEL_LSB = 0;
  localparam int COMP_SEL_MSB = 2;

  // Field positions in the force enable register
  localparam int CONV_FORCE_BIT = 1;
  localparam int COMP_FORCE_BIT = 0;

  // Level select codes, shared by both sources
  typedef enum logic [2:0] {
    LVL_0V55 = 3'h0,
    LVL_1V1 = 3'h1,
    LVL_2V5 = 3'h2,
    LVL_4V3 = 3'h3,
    LVL_1V5 = 3'h4
  } level_code_e;

  // AHB transfer type and response codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic HRESP_OKAY = 1'h0;

endpackage : vref_ctrl_pkg
